// File: crosspoint_serial_config.sv
// serial configuration port: load shift register, pending bank and active matrix settings
`timescale 1ns/10ps
`default_nettype none
module crosspoint_serial_config #(
    parameter int FRAME_LEN = xpt_pkg::FRAME_BITS,
    parameter int WORD_LEN  = xpt_pkg::WORD_BITS
) (
    input  wire logic                 mclk,
    input  wire logic                 reset,
    input  wire logic                 sclk,
    input  wire logic                 cs_n,
    input  wire logic                 sdi,
    input  wire logic                 mode,
    input  wire logic                 cfg,
    input  wire logic                 all_off,
    input  wire logic                 all_on_first_input,
    output logic                      sdo,
    output logic [16*5-1:0]           out_sel,
    output logic [15:0]               out_en
);
    // timing overview
    // - every serial pin is seen two mclk edges late; sclk edges show up in that same cycle
    // - a bit is taken on the synced falling sclk, so sclk must stay high and low for
    //   more than one mclk period or an edge can be missed
    // - the load register doubles as the pending bank: a full frame is applied whole,
    //   an addressed word only touches the output that it names
    // - sdo is registered, so a cascaded device sees each bit a few mclk after the fall,
    //   well before the next rising sclk at the intended serial rate
    // - the two level pins reach the outputs with no clock at all; their copy into the
    //   active bank waits for two flops, trading a few cycles for a clean capture
    // - mode is looked at when the strobe arrives, not while bits shift in
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ARMED = 2'b01,
        ST_SHIFT = 2'b10
    } phase_t;

    typedef struct packed {
        phase_t                         phase;
        logic [FRAME_LEN-1:0]           load;
        logic                           dirty;
        logic [xpt_pkg::N_OUT*5-1:0]    act_sel;
        logic [xpt_pkg::N_OUT-1:0]      act_off;
        logic                           sdo;
        logic [1:0]                     lvl_s1;
        logic [1:0]                     lvl_s2;
    } st_t;

    st_t st_ff;
    st_t nxt_st;

    xpt_sync_if sy ();

    xpt_pin_sync u_sync (
        .mclk  (mclk),
        .reset (reset),
        .sclk  (sclk),
        .cs_n  (cs_n),
        .sdi   (sdi),
        .mode  (mode),
        .cfg   (cfg),
        .sy    (sy.src)
    );

    logic [3:0] w_out;
    logic [4:0] w_in;
    logic       w_off;
    logic       shift_now;
    logic       lvl_off;
    logic       lvl_on;

    // addressed word sits in the newest ten bits; bit 0 arrived first
    always_comb begin
        w_out = st_ff.load[FRAME_LEN-WORD_LEN+xpt_pkg::W_OUT_LSB +: 4];
        w_in  = st_ff.load[FRAME_LEN-WORD_LEN+xpt_pkg::W_IN_LSB +: 5];
        w_off = st_ff.load[FRAME_LEN-WORD_LEN+xpt_pkg::W_OFF_BIT];
    end

    // one shift per synced falling sclk while a frame is open; level pins after their sync
    always_comb begin
        shift_now = ~sy.cs_n && (st_ff.phase == ST_SHIFT) && sy.sclk_fall;
        lvl_off   = st_ff.lvl_s2[0];
        lvl_on    = st_ff.lvl_s2[1];
    end

    // select framing, shifting and transfer to the active bank
    always_comb begin
        nxt_st = st_ff;
        // level pins pass two flops before they may touch the bank
        nxt_st.lvl_s1 = {all_on_first_input, all_off};
        nxt_st.lvl_s2 = st_ff.lvl_s1;
        if (sy.cs_n) begin
            nxt_st.phase = ST_IDLE;
        end else begin
            case (st_ff.phase)
                ST_IDLE: begin
                    if (sy.sclk_rise) begin
                        nxt_st.phase = ST_SHIFT;
                    end
                end
                ST_ARMED: nxt_st.phase = ST_SHIFT;
                ST_SHIFT: begin
                    // bits enter at the top, move toward bit 0 and leave there
                    if (shift_now) begin
                        nxt_st.load  = {sy.sdi, st_ff.load[FRAME_LEN-1:1]};
                        nxt_st.sdo   = st_ff.load[0];
                        nxt_st.dirty = 1'h1;
                    end
                end
                default: nxt_st.phase = ST_IDLE;
            endcase
        end
        // configure is independent of select; a repeat with nothing new is a no-op
        if (sy.cfg_rise && st_ff.dirty) begin
            // a bit landing in this same cycle keeps the bank marked as pending
            nxt_st.dirty = shift_now;
            if (sy.mode) begin
                nxt_st.act_sel[w_out*5 +: 5] = w_in;
                nxt_st.act_off[w_out]        = w_off;
            end else begin
                for (int i = 0; i < xpt_pkg::N_OUT; i++) begin
                    nxt_st.act_sel[i*5 +: 5] = st_ff.load[i*xpt_pkg::GRP_BITS +: 5];
                    nxt_st.act_off[i] = st_ff.load[i*xpt_pkg::GRP_BITS+xpt_pkg::G_OFF_BIT];
                end
            end
        end
        // level pins win over a strobe in the same cycle and overwrite the active bank
        if (lvl_off) begin
            nxt_st.act_sel = '0;
            nxt_st.act_off = '1;
        end else if (lvl_on) begin
            nxt_st.act_sel = '0;
            nxt_st.act_off = '0;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            st_ff       <= '0;
            st_ff.phase <= ST_IDLE;
            st_ff.act_off <= '1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // level pins also force outputs combinationally so no clock is needed;
    // this is the only place that reads them unsynchronised, on purpose
    always_comb begin
        if (all_off) begin
            out_sel = '0;
            out_en  = '0;
        end else if (all_on_first_input) begin
            out_sel = '0;
            out_en  = '1;
        end else begin
            out_sel = st_ff.act_sel;
            out_en  = ~st_ff.act_off;
        end
    end

    assign sdo = st_ff.sdo;
endmodule // crosspoint_serial_config
`default_nettype wire

// File: tb_top.sv
// self-checking bench for the crosspoint serial config port
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic        mclk = 1'h0;
    logic        reset = 1'h1;
    logic        all_off = 1'h0;
    logic        all_on_first_input = 1'h0;
    wire logic   sclk, cs_n, sdi, mode, cfg;
    logic        sdo;
    logic [79:0] out_sel;
    logic [15:0] out_en;
    logic [95:0] cur;
    logic [191:0] so;
    int          mismatches = 0;
    int          n_tests = 0;
    always #10 mclk = ~mclk;
    xpt_host i_xpt_host (.mclk(mclk), .sdo(sdo), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
        .mode(mode), .cfg(cfg));
    crosspoint_serial_config i_crosspoint_serial_config (.mclk(mclk), .reset(reset), .sclk(sclk),
        .cs_n(cs_n), .sdi(sdi), .mode(mode), .cfg(cfg), .all_off(all_off),
        .all_on_first_input(all_on_first_input), .sdo(sdo), .out_sel(out_sel), .out_en(out_en));
    task automatic chk(input string what, input logic [95:0] exp, input logic [95:0] got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // expected outputs from the six-bit groups of the current frame
    task automatic chk_out();
        logic [79:0] es;
        logic [15:0] ee;
        for (int i = 0; i < 16; i++) begin
            es[i*5+:5] = cur[i*6+:5];
            ee[i] = ~cur[i*6+5];
        end
        chk("out_sel", {16'h0, es}, {16'h0, out_sel});
        chk("out_en", {80'h0, ee}, {80'h0, out_en});
    endtask
    task automatic t_frame(input logic [95:0] f, input logic see_old);
        i_xpt_host.xfer({96'h0, f}, 96, 1'h0, so);
        if (see_old) chk("sdo", cur, so[95:0]);
        i_xpt_host.pulse_cfg();
        cur = f;
        chk_out();
    endtask
    // chained frames: the far one goes first and must leave on sdo after 96 clocks
    task automatic t_chain(input logic [95:0] near, input logic [95:0] far);
        i_xpt_host.xfer({near, far}, 192, 1'h0, so);
        chk("sdo stale", cur, so[95:0]);
        chk("sdo far", far, so[191:96]);
        i_xpt_host.pulse_cfg();
        cur = near;
        chk_out();
    endtask
    task automatic t_word(input logic [3:0] o, input logic [4:0] in, input logic off);
        i_xpt_host.xfer({182'h0, off, in, o}, 10, 1'h1, so);
        i_xpt_host.pulse_cfg();
        cur[o*6+:6] = {off, in};
        chk_out();
    endtask
    task automatic t_quiet();
        i_xpt_host.idle(12);
        i_xpt_host.pulse_cfg();
        chk_out();
    endtask
    task automatic t_level();
        all_off <= 1'h1;
        i_xpt_host.w(4);
        cur = {16{6'h20}};
        chk_out();
        all_off <= 1'h0;
        i_xpt_host.w(4);
        chk_out();
        all_on_first_input <= 1'h1;
        i_xpt_host.w(4);
        cur = 96'h0;
        chk_out();
        all_on_first_input <= 1'h0;
        i_xpt_host.pulse_cfg();
        chk_out();
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge mclk);
        reset <= 1'h0;
        i_xpt_host.w(4);
        t_frame(96'h9A5C3E71D208F6B41C8E57A3, 1'h0);
        t_frame(96'h36C1A4F08E25B7D90F3C6A18, 1'h1);
        t_chain(96'h5E2B907C4DA136F8E1B0C72A, 96'hC3947A1E6B08F25D39E4A6B1);
        t_word(4'hF, 5'h1F, 1'h0);
        t_word(4'h0, 5'h11, 1'h1);
        t_quiet();
        t_level();
        report_and_stop();
    end
endmodule // tb_top
`default_nettype wire

// File: xpt_chk.sv
// port checker for the crosspoint serial config block
`timescale 1ns/10ps
`default_nettype none
module xpt_chk #(parameter int FRAME_LEN = 96, parameter int WORD_LEN = 10) (
    input wire logic        mclk,
    input wire logic        reset,
    input wire logic        cs_n,
    input wire logic        cfg,
    input wire logic        all_off,
    input wire logic        all_on_first_input,
    input wire logic        sdo,
    input wire logic [79:0] out_sel,
    input wire logic [15:0] out_en
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);
    // level pins act at once, no serial clock involved
    a_off_all_dis: assert property (all_off |-> out_en == 16'h0)
        else $error("output enabled under all-off");
    a_off_sel_zero: assert property (all_off |-> out_sel == 80'h0)
        else $error("input select not zero under all-off");
    a_all_on_zero: assert property (all_on_first_input && !all_off
        |-> out_en == 16'hFFFF && out_sel == 80'h0) else $error("not all on to input zero");
    // the bank takes a level pin after its two-flop sync, so look three edges back
    a_off_overwrite: assert property ($past(all_off, 3) && !all_off
        && !all_on_first_input |-> out_en == 16'h0 && out_sel == 80'h0)
        else $error("all-off not kept in bank");
    a_on_overwrite: assert property ($past(all_on_first_input, 3)
        && !$past(all_off, 3) && !all_on_first_input && !all_off
        |-> out_en == 16'hFFFF && out_sel == 80'h0) else $error("all-on not kept in bank");
    // settings move only with a strobe or a level pin
    a_hold_no_cfg: assert property ((!cfg && !all_off && !all_on_first_input) [*8]
        |-> $stable(out_en) && $stable(out_sel)) else $error("outputs moved without strobe");
    a_sdo_quiet: assert property (cs_n [*8] |-> $stable(sdo))
        else $error("sdo moved while deselected");
    // select reaches the shifter two flops late and sdo is one more register behind
    a_sdo_sel: assert property ($changed(sdo) |-> !$past(cs_n, 3))
        else $error("sdo shifted without select");
    c_cfg: cover property ($rose(cfg));
    c_sdo: cover property ($changed(sdo));
    c_on: cover property ($rose(all_on_first_input));
endmodule // xpt_chk
bind crosspoint_serial_config xpt_chk #(.FRAME_LEN(FRAME_LEN), .WORD_LEN(WORD_LEN)) i_xpt_chk (
    .mclk(mclk), .reset(reset), .cs_n(cs_n), .cfg(cfg), .all_off(all_off),
    .all_on_first_input(all_on_first_input), .sdo(sdo), .out_sel(out_sel), .out_en(out_en));
`default_nettype wire

// File: xpt_host.sv
// host model driving the serial pins of the crosspoint port
`timescale 1ns/10ps
`default_nettype none
module xpt_host (
    input  wire logic mclk,
    input  wire logic sdo,
    output var logic  sclk = 1'h0,
    output var logic  cs_n = 1'h1,
    output var logic  sdi = 1'h0,
    output var logic  mode = 1'h0,
    output var logic  cfg = 1'h0
);
    task automatic w(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // 160 ns serial clock, 3 high 5 low; low before select falls, one extra pulse after select rises; up to two frames
    task automatic xfer(input logic [191:0] d, input int n, input logic m,
                        output logic [191:0] so);
        so = 192'h0;
        mode <= m; // held for the whole transfer
        cs_n <= 1'h0; // falls with clock low, before first rise
        w(4);
        for (int i = 0; i < n; i++) begin
            sclk <= 1'h1; // first rise syncs, each fall captures
            sdi <= d[i];
            w(3);
            sclk <= 1'h0;
            w(5);
            so[i] = sdo;
        end
        cs_n <= 1'h1;
        w(3);
        sclk <= 1'h1; // one more rise after select goes high
        w(3);
        sclk <= 1'h0;
        sdi <= ~sdi; // released line must not keep the last bit
        w(5);
    endtask
    // strobe only once all bits are in
    task automatic pulse_cfg();
        cfg <= 1'h1;
        w(4);
        cfg <= 1'h0;
        w(8);
    endtask
    // clocking and data with select high
    task automatic idle(input int n);
        repeat (n) begin
            sclk <= 1'h1;
            sdi <= ~sdi;
            w(3);
            sclk <= 1'h0;
            w(5);
        end
    endtask
endmodule // xpt_host
`default_nettype wire

// File: xpt_pin_sync.sv
// two-flop synchronisers and edge finders for the serial pins
`timescale 1ns/10ps
`default_nettype none
module xpt_pin_sync (
    input  wire logic mclk,
    input  wire logic reset,
    input  wire logic sclk,
    input  wire logic cs_n,
    input  wire logic sdi,
    input  wire logic mode,
    input  wire logic cfg,
    xpt_sync_if.src   sy
);
    typedef struct packed {
        logic [4:0] s1;
        logic [4:0] s2;
        logic       sclk_d;
        logic       cfg_d;
    } st_t;
    st_t st_ff;
    st_t nxt_st;

    // first stage feeds only second stage; edges taken from second stage
    always_comb begin
        nxt_st        = st_ff;
        nxt_st.s1     = {cfg, mode, sdi, cs_n, sclk};
        nxt_st.s2     = st_ff.s1;
        nxt_st.sclk_d = st_ff.s2[0];
        nxt_st.cfg_d  = st_ff.s2[4];
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            st_ff <= '{s1: 5'h02, s2: 5'h02, sclk_d: 1'h0, cfg_d: 1'h0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign sy.sclk_rise = st_ff.s2[0] & ~st_ff.sclk_d;
    assign sy.sclk_fall = ~st_ff.s2[0] & st_ff.sclk_d;
    assign sy.cs_n      = st_ff.s2[1];
    assign sy.sdi       = st_ff.s2[2];
    assign sy.mode      = st_ff.s2[3];
    assign sy.cfg_rise  = st_ff.s2[4] & ~st_ff.cfg_d;
endmodule // xpt_pin_sync
`default_nettype wire

// File: xpt_pkg.sv
// package with frame layout and sizes for the serial config port
`default_nettype none
package xpt_pkg;
    localparam int N_OUT       = 16;
    localparam int N_IN_BITS   = 5;
    localparam int N_OUT_BITS  = 4;
    localparam int GRP_BITS    = 6;
    localparam int FRAME_BITS  = 96;
    localparam int WORD_BITS   = 10;
    localparam int W_OUT_LSB   = 0;
    localparam int W_IN_LSB    = 4;
    localparam int W_OFF_BIT   = 9;
    localparam int G_OFF_BIT   = 5;
    localparam logic [4:0] IN_ZERO = 5'h00;
    localparam logic       OFF_VAL = 1'h1;
    localparam logic       ON_VAL  = 1'h0;
endpackage
`default_nettype wire

// File: xpt_sync_if.sv
// interface carrying synchronised pin levels and their edges into the port logic
`timescale 1ns/10ps
`default_nettype none
interface xpt_sync_if;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_n;
    logic sdi;
    logic mode;
    logic cfg_rise;
    modport src (output sclk_rise, output sclk_fall, output cs_n, output sdi, output mode,
                 output cfg_rise);
    modport dst (input sclk_rise, input sclk_fall, input cs_n, input sdi, input mode,
                 input cfg_rise);
endinterface
`default_nettype wire
